//--- common/sac_pkg.sv
package sac_pkg;
  // bus geometry and register indices (byte address is four times the index)
  localparam int SAC_ADR_W = 10;
  localparam int SAC_DAT_W = 32;
  localparam logic [7:0] SAC_IDX_RES_LO = 8'h9C;
  localparam logic [7:0] SAC_IDX_RES_HI = 8'h9D;
  localparam logic [7:0] SAC_IDX_CTRL = 8'h9E;
  localparam logic [7:0] SAC_IDX_FMT = 8'h9F;
  localparam logic [7:0] SAC_IDX_STAT = 8'hA0;
  // converter_control fields
  localparam int SAC_CTL_ON = 0;
  localparam int SAC_CTL_GO = 1;
  localparam int SAC_CTL_CHS_LO = 2;
  localparam int SAC_CTL_CS_LO = 6;
  // format_and_channel_msb fields
  localparam int SAC_FMT_MSB = 6;
  localparam int SAC_FMT_RJ = 7;
  // status fields
  localparam int SAC_STAT_DONE = 0;
  localparam int SAC_STAT_IE = 1;
  localparam logic [7:0] SAC_REG_RST = 8'h00;
  // conversion clock select codes and dividers
  localparam logic [1:0] SAC_CS_DIV8 = 2'h0;
  localparam logic [1:0] SAC_CS_DIV16 = 2'h1;
  localparam logic [1:0] SAC_CS_DIV32 = 2'h2;
  localparam logic [1:0] SAC_CS_RC = 2'h3;
  localparam logic [4:0] SAC_DIV8_M1 = 5'h07;
  localparam logic [4:0] SAC_DIV16_M1 = 5'h0F;
  localparam logic [4:0] SAC_DIV32_M1 = 5'h1F;
  // channel code of the internal fixed reference
  localparam logic [4:0] SAC_CH_REF = 5'h1A;
  // timing in bit periods and clocks
  localparam logic [5:0] SAC_TAD_LAST = 6'h30;
  localparam logic [5:0] SAC_DEC_END = 6'h30;
  localparam logic [1:0] SAC_DEC_PHASE = 2'h3;
  localparam logic [1:0] SAC_ABORT_LAST = 2'h1;
  localparam logic [2:0] SAC_INSTR_LAST = 3'h3;
  localparam logic [11:0] SAC_SAR_MSB = 12'h800;
  localparam logic [3:0] SAC_TOP_BIT = 4'hB;
  // converter sequencer states
  typedef enum logic [3:0] {
    SAC_ST_IDLE = 4'b0001,
    SAC_ST_DELAY = 4'b0010,
    SAC_ST_CONV = 4'b0100,
    SAC_ST_ABORT = 4'b1000
  } sac_state_type;
endpackage : sac_pkg

//--- hdl/sac_result_pack.sv
`timescale 1ns/1ns
module sac_result_pack (
  input wire logic [11:0] res_i, // finished conversion code
  input wire logic rj_i, // right alignment chosen
  output logic [7:0] hi_o, // result_high byte
  output logic [7:0] lo_o // result_low byte
);
  // lay the code into two bytes, unused bits zero; right alignment keeps only bits 11 to 2
  always_comb
  begin
    if (rj_i)
    begin
      hi_o = {6'h00, res_i[11:10]};
      lo_o = res_i[9:2];
    end
    else
    begin
      hi_o = res_i[11:4];
      lo_o = {res_i[3:0], 4'h0};
    end
  end
endmodule : sac_result_pack

//--- hdl/sac_tad_gen.sv
`timescale 1ns/1ns
module sac_tad_gen (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic en_i, // converter powered
  input wire logic [1:0] sel_i, // conversion clock select
  input wire logic rc_clk_i, // dedicated rc oscillator pin
  output logic tick_o // one pulse per bit period
);
  import sac_pkg::*;
  typedef struct packed {
    logic [4:0] cnt;
    logic s1;
    logic s2;
    logic s3;
    logic filt;
  } sac_tad_type;
  sac_tad_type st_r, st_nxt;

  // divider limit for the selected system clock ratio
  function automatic logic [4:0] sac_div_last(input logic [1:0] sel);
    case (sel)
      SAC_CS_DIV8: sac_div_last = SAC_DIV8_M1;
      SAC_CS_DIV16: sac_div_last = SAC_DIV16_M1;
      default: sac_div_last = SAC_DIV32_M1;
    endcase
  endfunction : sac_div_last

  // divider and rc pin synchroniser, change taken when stages 2 and 3 agree
  always_comb
  begin
    st_nxt = st_r;
    tick_o = 1'b0;
    st_nxt.s1 = rc_clk_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3)
      st_nxt.filt = st_r.s3;
    if (!en_i)
      st_nxt.cnt = 5'h00;
    else if (sel_i == SAC_CS_RC)
      tick_o = (st_r.s2 == st_r.s3) && st_r.s3 && !st_r.filt;
    else if (st_r.cnt == sac_div_last(sel_i))
    begin
      st_nxt.cnt = 5'h00;
      tick_o = 1'b1;
    end
    else
      st_nxt.cnt = st_r.cnt + 5'h01;
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule : sac_tad_gen

//--- hdl/sac_ctrl.sv
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ns
module sac_ctrl (
  input wire logic clk_i, // system clock, 10 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic [sac_pkg::SAC_ADR_W-1:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [sac_pkg::SAC_DAT_W-1:0] dat_i, // wishbone write data
  output logic [sac_pkg::SAC_DAT_W-1:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic sleep_i, // cpu is in sleep
  input wire logic rc_clk_i, // dedicated rc oscillator pin
  input wire logic cmp_i, // comparator: input at or above trial level
  output logic power_o, // analog converter powered
  output logic sample_o, // sample-and-hold tracking the input
  output logic [4:0] channel_o, // selected channel code
  output logic ref_sel_o, // internal fixed reference selected
  output logic [11:0] dac_code_o, // successive approximation trial code
  output logic done_o, // conversion_done_flag level
  output logic wake_o // wake request to the cpu
);
  import sac_pkg::*;

  typedef struct packed {
    sac_state_type st;
    logic on;
    logic go;
    logic [3:0] channel_select;
    logic [1:0] cs;
    logic rj;
    logic chs_msb;
    logic done;
    logic irq_en;
    logic shut;
    logic slp_d;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [11:0] sar;
    logic [5:0] tcnt;
    logic [1:0] acnt;
    logic [2:0] dcnt;
    logic c1;
    logic c2;
    logic c3;
    logic cmp_f;
    logic ack;
    logic [7:0] rdata;
  } sac_ctrl_type;
  sac_ctrl_type st_r, st_nxt;

  logic tick;
  logic powered;
  logic [7:0] pk_hi;
  logic [7:0] pk_lo;
  logic complete;
  logic sw_abort;
  logic start;
  logic sleep_kill;

  // single trial bit, used for clearing and setting
  function automatic logic [11:0] sac_bit(input logic [3:0] idx);
    sac_bit = 12'h001 << idx;
  endfunction : sac_bit

  assign powered = st_r.on && !st_r.shut;
  assign power_o = powered;
  assign sample_o = powered && (st_r.st == SAC_ST_IDLE);
  assign channel_o = {st_r.chs_msb, st_r.channel_select};
  assign ref_sel_o = (channel_o == SAC_CH_REF);
  assign dac_code_o = st_r.sar;
  assign done_o = st_r.done;
  assign wake_o = sleep_i && st_r.irq_en && st_r.done;
  assign ack_o = st_r.ack;
  assign dat_o = {24'h000000, st_r.rdata};

  sac_tad_gen u_tad (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(powered),
    .sel_i(st_r.cs),
    .rc_clk_i(rc_clk_i),
    .tick_o(tick)
  );

  sac_result_pack u_pack (
    .res_i(st_r.sar),
    .rj_i(st_r.rj),
    .hi_o(pk_hi),
    .lo_o(pk_lo)
  );

  // bus, synchroniser, sequencer and flags
  always_comb
  begin
    logic req;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [3:0] b;
    req = cyc_i && stb_i;
    wr = req && st_r.ack && we_i && sel_i[0];
    idx = adr_i[9:2];
    wd = dat_i[7:0];
    b = SAC_TOP_BIT - st_r.tcnt[5:2];
    st_nxt = st_r;
    start = 1'b0;
    sw_abort = 1'b0;
    complete = 1'b0;
    sleep_kill = 1'b0;
    st_nxt.ack = req && !st_r.ack;
    // comparator pin synchroniser
    st_nxt.c1 = cmp_i;
    st_nxt.c2 = st_r.c1;
    st_nxt.c3 = st_r.c2;
    if (st_r.c2 == st_r.c3)
      st_nxt.cmp_f = st_r.c3;
    // read data latched together with ack
    if (req && !st_r.ack)
    begin
      case (idx)
        SAC_IDX_RES_LO: st_nxt.rdata = st_r.res_lo;
        SAC_IDX_RES_HI: st_nxt.rdata = st_r.res_hi;
        SAC_IDX_CTRL: st_nxt.rdata = {st_r.cs, st_r.channel_select, st_r.go, st_r.on};
        SAC_IDX_FMT: st_nxt.rdata = {st_r.rj, st_r.chs_msb, 6'h00};
        SAC_IDX_STAT: st_nxt.rdata = {6'h00, st_r.irq_en, st_r.done};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // register writes at the edge where the master sees ack
    if (wr)
    begin
      case (idx)
        SAC_IDX_CTRL:
        begin
          st_nxt.on = wd[SAC_CTL_ON];
          st_nxt.channel_select = wd[SAC_CTL_CHS_LO +: 4];
          st_nxt.cs = wd[SAC_CTL_CS_LO +: 2];
          // a go written during the post-abort wait is dropped, not half-started
          if (wd[SAC_CTL_GO] && st_r.on && !st_r.go && !st_r.shut && (st_r.st == SAC_ST_IDLE))
            start = 1'b1;
          if (!wd[SAC_CTL_GO] && st_r.go)
            sw_abort = 1'b1;
        end
        SAC_IDX_FMT:
        begin
          st_nxt.rj = wd[SAC_FMT_RJ];
          st_nxt.chs_msb = wd[SAC_FMT_MSB];
        end
        SAC_IDX_STAT:
        begin
          st_nxt.irq_en = wd[SAC_STAT_IE];
          if (!wd[SAC_STAT_DONE])
            st_nxt.done = 1'b0;
        end
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
    // sleep entry and exit
    st_nxt.slp_d = sleep_i;
    if (!sleep_i)
      st_nxt.shut = 1'b0;
    if (sleep_i && !st_r.slp_d && (st_r.cs != SAC_CS_RC) && st_r.on)
      sleep_kill = 1'b1;
    // conversion sequencer
    case (st_r.st)
      SAC_ST_IDLE:
      begin
        if (start)
        begin
          st_nxt.go = 1'b1;
          st_nxt.dcnt = 3'h0;
          st_nxt.tcnt = 6'h00;
          st_nxt.sar = SAC_SAR_MSB;
          st_nxt.st = (st_r.cs == SAC_CS_RC) ? SAC_ST_DELAY : SAC_ST_CONV;
        end
      end
      SAC_ST_DELAY:
      begin
        st_nxt.dcnt = st_r.dcnt + 3'h1;
        if (st_r.dcnt == SAC_INSTR_LAST)
          st_nxt.st = SAC_ST_CONV;
      end
      SAC_ST_CONV:
      begin
        if (tick)
        begin
          st_nxt.tcnt = st_r.tcnt + 6'h01;
          if ((st_r.tcnt[1:0] == SAC_DEC_PHASE) && (st_r.tcnt < SAC_DEC_END))
          begin
            if (!st_r.cmp_f)
              st_nxt.sar = st_r.sar & ~sac_bit(b);
            if (b != 4'h0)
              st_nxt.sar = st_nxt.sar | sac_bit(b - 4'h1);
          end
          if (st_r.tcnt == SAC_TAD_LAST)
          begin
            complete = 1'b1;
            st_nxt.go = 1'b0;
            st_nxt.res_hi = pk_hi;
            st_nxt.res_lo = pk_lo;
            st_nxt.st = SAC_ST_IDLE;
            if (sleep_i && (st_r.cs == SAC_CS_RC) && !st_r.irq_en)
              st_nxt.shut = 1'b1;
          end
        end
      end
      SAC_ST_ABORT:
      begin
        if (tick)
        begin
          st_nxt.acnt = st_r.acnt + 2'h1;
          if (st_r.acnt == SAC_ABORT_LAST)
            st_nxt.st = SAC_ST_IDLE;
        end
      end
      default: st_nxt.st = SAC_ST_IDLE;
    endcase
    // done flag: a completion wins over a clear in the same cycle
    if (complete)
      st_nxt.done = 1'b1;
    // software abort leaves the result registers untouched
    if (sw_abort && !complete)
    begin
      st_nxt.go = 1'b0;
      st_nxt.acnt = 2'h0;
      st_nxt.st = SAC_ST_ABORT;
    end
    // power loss ends any conversion; results load only if it completes in that same cycle
    if (sleep_kill || !st_nxt.on)
    begin
      if (sleep_kill)
        st_nxt.shut = 1'b1;
      st_nxt.go = 1'b0;
      st_nxt.st = SAC_ST_IDLE;
    end
  end

  // state register, reset clears everything except the state, which loads SAC_ST_IDLE
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
      st_r.st <= SAC_ST_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // checks
  chk_go_needs_on: assert property ($rose(st_r.go) |-> $past(st_r.on))
    else $error("go set while converter was off");
  chk_done_clears_go: assert property (complete |=> (!st_r.go && st_r.done))
    else $error("completion did not clear go and set done");
  chk_abort_keeps_res: assert property ((sw_abort && !complete && st_nxt.on && !sleep_kill)
    |=> ($stable(st_r.res_hi) && $stable(st_r.res_lo) && st_r.st == SAC_ST_ABORT))
    else $error("abort changed result or skipped wait");
  chk_abort_two_tad: assert property ((st_r.st == SAC_ST_ABORT && tick
    && st_r.acnt == 2'h1 && !sleep_kill && st_r.on) |=> st_r.st == SAC_ST_IDLE)
    else $error("abort wait not two bit periods");
  chk_rc_start_delay: assert property ((start && st_r.cs == SAC_CS_RC && st_nxt.on
    && !sleep_kill) |=> (st_r.st == SAC_ST_DELAY) [*4] ##1 (st_r.st == SAC_ST_CONV || !st_r.on))
    else $error("rc start delay wrong");
  chk_sleep_abort: assert property ((sleep_kill && st_r.go) |=> (!power_o && !st_r.go))
    else $error("sleep did not abort conversion");
  chk_off_no_power: assert property (!st_r.on |-> (!power_o && !st_r.go))
    else $error("converter powered while off");
  chk_done_sticky: assert property ((st_r.done && !(wr_stat_clear())) |=> st_r.done)
    else $error("done flag dropped without clear");
  chk_rj_zero_top: assert property ((complete && st_r.rj) |=> st_r.res_hi[7:2] == 6'h00)
    else $error("right aligned high byte has upper bits");
  chk_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> (!st_r.on && !st_r.go && !power_o))
    else $error("reset left converter active");

  // helper for the sticky flag check
  function automatic logic wr_stat_clear();
    wr_stat_clear = cyc_i && stb_i && st_r.ack && we_i && sel_i[0]
      && (adr_i[9:2] == SAC_IDX_STAT) && !dat_i[SAC_STAT_DONE];
  endfunction : wr_stat_clear
endmodule : sac_ctrl

//--- bench/sac_analog_model.sv
`timescale 1ns/1ns
module sac_analog_model #(
  parameter int RC_HALF_NS = 600
) (
  input wire logic clk_i, // system clock
  input wire logic power_i, // converter powered
  input wire logic sample_i, // sample-and-hold tracking
  input wire logic [11:0] dac_code_i, // trial code
  input wire logic [11:0] level_i, // analog input level as a code
  output logic cmp_o, // input at or above trial level
  output logic rc_clk_o // free running rc oscillator
);
  logic [11:0] held = 12'h000;
  logic flip = 1'b0;
  // free running oscillator, phase unrelated to clk_i
  initial
  begin
    rc_clk_o = 1'b0;
    #37;
    forever #RC_HALF_NS rc_clk_o = ~rc_clk_o;
  end
  // hold tracks while sampling and freezes during a conversion
  always @(posedge clk_i)
  begin
    flip <= ~flip;
    if (sample_i)
      held <= level_i;
  end
  // an unpowered comparator gives nothing useful, so it toggles
  assign cmp_o = power_i ? (held >= dac_code_i) : flip;
endmodule : sac_analog_model

//--- bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import sac_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [SAC_ADR_W-1:0] adr_i = '0;
  logic [3:0] sel_i = 4'h1;
  logic [SAC_DAT_W-1:0] dat_i = '0;
  logic sleep_i = 1'b0;
  logic [SAC_DAT_W-1:0] dat_o;
  logic ack_o, rc_clk, cmp, power_o, sample_o, ref_sel_o, done_o, wake_o;
  logic [4:0] channel_o;
  logic [11:0] dac_code_o;
  logic [11:0] level = 12'h000;
  logic [15:0] exp_res = 16'h0000;
  logic [7:0] q;
  logic ie = 1'b0;
  int seed = 64;
  int fail_count = 0;
  int n_compared = 0;

  // 10 MHz system clock
  always #50 clk_i = ~clk_i;

  sac_ctrl dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .sleep_i, .rc_clk_i(rc_clk), .cmp_i(cmp), .power_o, .sample_o, .channel_o, .ref_sel_o,
    .dac_code_o, .done_o, .wake_o);

  sac_analog_model model (.clk_i, .power_i(power_o), .sample_i(sample_o),
    .dac_code_i(dac_code_o), .level_i(level), .cmp_o(cmp), .rc_clk_o(rc_clk));

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one classic bus cycle, read data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    // no cycle count assumed for the answer; the watchdog ends a hang
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] idx, input string n, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(n, {8'h00, e}, {8'h00, q});
  endtask : rd

  // expected result register pair {high, low}
  function automatic logic [15:0] pack(input logic rj, input logic [11:0] v);
    return rj ? {6'h00, v[11:10], v[9:2]} : {v[11:4], v[3:0], 4'h0};
  endfunction : pack

  // md: 0 plain, 1 sleep during run, 2 software abort, 3 sleep abort
  task automatic conv(input logic [1:0] cs, input logic rj, input logic [4:0] ch,
      input logic [11:0] v, input int md);
    int n;
    int tad;
    n = 0;
    tad = 8 << cs;
    level <= v;
    wb(1'b1, SAC_IDX_STAT, {6'h00, ie, 1'b0});
    wb(1'b1, SAC_IDX_FMT, {rj, ch[4], 6'h00});
    wb(1'b1, SAC_IDX_CTRL, {cs, ch[3:0], 2'b01});
    // acquisition wait; channel outputs are looked at once the write edge has passed
    repeat (20) @(posedge clk_i);
    chk("done cleared", 16'h0000, {15'h0, done_o});
    chk("channel", {11'h000, ch}, {11'h000, channel_o});
    chk("reference", {15'h0, ch == SAC_CH_REF}, {15'h0, ref_sel_o});
    wb(1'b1, SAC_IDX_CTRL, {cs, ch[3:0], 2'b11});
    rd(SAC_IDX_CTRL, "busy go", {cs, ch[3:0], 2'b11});
    if (md == 1)
      sleep_i <= 1'b1;
    if (md >= 2)
    begin
      repeat (100) @(posedge clk_i);
      if (md == 2)
        wb(1'b1, SAC_IDX_CTRL, {cs, ch[3:0], 2'b01});
      else
        sleep_i <= 1'b1;
      if (md == 3)
      begin
        repeat (3) @(posedge clk_i);
        chk("sleep power", 16'h0000, {15'h0, power_o});
        rd(SAC_IDX_CTRL, "sleep go", {cs, ch[3:0], 2'b01});
        sleep_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("wake power", 16'h0001, {15'h0, power_o});
      end
      else
      begin
        while (sample_o !== 1'b1 && n < 300)
        begin
          @(posedge clk_i);
          n++;
        end
        chk("abort gap", 16'h0001, {15'h0, n >= tad && n <= 3 * tad + 4});
      end
      chk("no done", 16'h0000, {15'h0, done_o});
    end
    else
    begin
      while (done_o !== 1'b1 && n < 5000)
      begin
        @(posedge clk_i);
        n++;
      end
      if (cs != SAC_CS_RC)
        chk("conv time", 16'h0001, {15'h0, n >= 48 * tad - 2 && n <= 49 * tad + 8});
      chk("wake", {15'h0, md == 1 && ie}, {15'h0, wake_o});
      chk("power", {15'h0, !(md == 1 && !ie)}, {15'h0, power_o});
      sleep_i <= 1'b0;
      rd(SAC_IDX_CTRL, "go cleared", {cs, ch[3:0], 2'b01});
      exp_res = pack(rj, v);
      chk("done held", 16'h0001, {15'h0, done_o});
    end
    rd(SAC_IDX_RES_HI, "result high", exp_res[15:8]);
    rd(SAC_IDX_RES_LO, "result low", exp_res[7:0]);
    $display("conversion mode %0d done", md);
  endtask : conv

  // main sequence
  initial
  begin
    int i;
    logic [4:0] ch;
    logic [11:0] v;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SAC_IDX_CTRL, "ctrl reset", SAC_REG_RST);
    rd(SAC_IDX_FMT, "fmt reset", SAC_REG_RST);
    rd(8'h10, "unmapped", 8'h00);
    wb(1'b1, SAC_IDX_CTRL, 8'h02);
    rd(SAC_IDX_CTRL, "go while off", 8'h00);
    wb(1'b1, SAC_IDX_FMT, 8'hFF);
    rd(SAC_IDX_FMT, "fmt unused", 8'hC0);
    wb(1'b1, SAC_IDX_RES_LO, 8'hFF);
    rd(SAC_IDX_RES_LO, "read only", 8'h00);
    $display("register test done");
    for (i = 0; i < 6; i++)
    begin
      ch = 5'($unsigned($random(seed)) % 16);
      if (ch > 5'h0B)
        ch = ch + 5'h0B;
      v = i == 0 ? 12'h000 : i == 5 ? 12'hFFF : 12'($random(seed));
      conv(2'(i / 2), 1'(i % 2), ch, v, 0);
    end
    conv(SAC_CS_DIV8, 1'b0, SAC_CH_REF, 12'h5A3, 2);
    ie = 1'b1;
    conv(SAC_CS_RC, 1'b1, 5'h03, 12'($random(seed)), 1);
    ie = 1'b0;
    conv(SAC_CS_RC, 1'b0, 5'h17, 12'($random(seed)), 1);
    conv(SAC_CS_DIV16, 1'b0, 5'h0B, 12'h3C1, 3);
    wb(1'b1, SAC_IDX_CTRL, 8'h03);
    repeat (50) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("reset power", 16'h0000, {15'h0, power_o});
    rd(SAC_IDX_CTRL, "reset ctrl", 8'h00);
    rd(SAC_IDX_RES_LO, "reset result", 8'h00);
    $display("reset test done");
    close_out;
  end

  // cuts a hang short
  initial
  begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    close_out;
  end
endmodule : tb_top
